// ===== glp_pkg.sv
// Shared constants, field positions and carrier types for the pin and indicator block.
// Assumes one 250 MHz system clock and an APB register port with 32-bit data.
package glp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] CFG_OFS = 8'h88;     // Pin and indicator configuration
   localparam logic [7:0] IRQ_STS_OFS = 8'h40; // Sticky pin interrupt status, read only
   localparam logic [7:0] IRQ_CLR_OFS = 8'h44; // Write one to clear status, write only
   localparam logic [7:0] IRQ_EN_OFS = 8'h48;  // Per-pin interrupt enable

   ////////////////////////////////////////////////////////////////////////////
   // Field low bits inside the configuration word
   localparam int LED_LSB = 28; // Indicator function select, three bits
   localparam int POL_LSB = 24; // Interrupt level select, three bits
   localparam int ROM_LSB = 20; // Serial memory pin function, three bits
   localparam int DRV_LSB = 16; // Driver type, three bits
   localparam int DIR_LSB = 8;  // Direction, three bits
   localparam int GPO_LSB = 3;  // Output-only values, two bits
   localparam int DAT_LSB = 0;  // Shared pin data, three bits

   // Writable bits; all others are reserved and read zero
   localparam logic [31:0] CFG_WMASK = 32'h7777_071f;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [2:0] IRQ_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt level qualification time
   localparam int IRQ_HOLD_NS = 40;
   localparam int CLK_PERIOD_NS = 4;
   // Least time, so rounded up to whole cycles
   localparam int IRQ_HOLD_CYC = (IRQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Serial memory pin function codes
   typedef enum logic [2:0] {
      ROM_EEPROM = 3'h0,
      ROM_GPO_BOTH = 3'h1,
      ROM_RSV_2 = 3'h2,
      ROM_GPO_RXDV = 3'h3,
      ROM_RSV_4 = 3'h4,
      ROM_TXEN_GPO = 3'h5,
      ROM_TXEN_RXDV = 3'h6,
      ROM_MII_CLKS = 3'h7
   } glp_rom_sel_t;

   // One pad: value and active-low output enable
   typedef struct packed {
      logic out;
      logic oe_n;
   } glp_pad_t;

   // Monitored link signals
   typedef struct packed {
      logic tx_en;
      logic rx_dv;
      logic tx_clk;
      logic rx_clk;
   } glp_mii_t;

   // Serial memory controller drive
   typedef struct packed {
      logic dio_out;
      logic dio_oe_n;
      logic clk;
   } glp_rom_ctl_t;

endpackage

// ===== glp_pin_cell.sv
// Drive selection for one shared pin: indicator or general-purpose, push-pull or open-drain.
// Assumes the caller registers the pad result before it reaches the pin.
`timescale 1ns/1ns
`default_nettype none
module glp_pin_cell (
   input wire logic led_sel,
   input wire logic led_src,
   input wire logic push_pull,
   input wire logic dir_out,
   input wire logic data,
   output glp_pkg::glp_pad_t pad
);
   // Indicator mode always drives; open-drain pulls low only for a zero
   assign pad.out = led_sel ? led_src : (push_pull & data);
   assign pad.oe_n = led_sel ? 1'b0 : (!dir_out ? 1'b1 : (push_pull ? 1'b0 : data));
endmodule // glp_pin_cell
`default_nettype wire

// ===== glp_irq_qual.sv
// Level qualifier: reports a hit once a pin has sat at its active level long enough.
// Assumes the pin level is already synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
module glp_irq_qual #(
   parameter int HOLD_CYC = glp_pkg::IRQ_HOLD_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin_level,
   input wire logic active_high,
   output logic hit
);
   localparam int CW = $clog2(HOLD_CYC + 1);
   localparam logic [CW-1:0] HOLD = CW'(HOLD_CYC);
   logic [CW-1:0] cnt_q; // Cycles spent at the active level, saturating
   logic [CW-1:0] cnt_d;
   wire logic active = (pin_level == active_high);

   // Any drop out of the active level restarts the count
   assign cnt_d = !active ? '0 : ((cnt_q == HOLD) ? cnt_q : cnt_q + 1'b1);
   assign hit = (cnt_q == HOLD);

   // Count register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // glp_irq_qual
`default_nettype wire

// ===== glp_gpio_cfg.sv
// Pin and indicator configuration block with APB register port and pin interrupts.
// Assumes pins and monitored signals are synchronous to clk_sys; pads are resolved outside.
//
// How it works
// - Bits 30:28 pick indicator or general-purpose
// - Bits 26:24 pick active level for interrupts
// - Interrupt reported only when pin enabled
// - Bits 22:20 steer serial memory pins
// - Fixed code table for memory pin functions
// - Bits 18:16 pick push-pull or open-drain
// - Bits 10:8 pick output or input direction
// - Bits 4:3 drive output-only pins 3, 4
// - Output pins drive their data bit
// - Data bits read back live pin state
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module glp_gpio_cfg #(
   parameter int NPIN = 3,
   parameter int ADDR_W = 8,
   parameter int HOLD_CYC = glp_pkg::IRQ_HOLD_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NPIN-1:0] pin_in,
   output glp_pkg::glp_pad_t [NPIN-1:0] pin_pad,
   input wire logic indicator_1,
   input wire logic indicator_2,
   input wire logic indicator_3,
   input wire glp_pkg::glp_rom_ctl_t rom_ctl,
   output logic rom_dio_in,
   input wire logic rom_data_pin_in,
   output glp_pkg::glp_pad_t rom_data_pin,
   output glp_pkg::glp_pad_t rom_clock_pin,
   input wire glp_pkg::glp_mii_t mii,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [31:0] cfg_q;            // Configuration word, writable bits only
   logic [31:0] cfg_d;
   logic [NPIN-1:0] sts_q;        // Sticky pin interrupt status
   logic [NPIN-1:0] sts_d;
   logic [NPIN-1:0] en_q;         // Pin interrupt enable
   logic [NPIN-1:0] en_d;
   logic [31:0] rdata_q;          // Read data, captured in the setup cycle
   logic [31:0] rdata_d;
   glp_pkg::glp_pad_t [NPIN-1:0] pad_d; // Next shared pad drive
   glp_pkg::glp_pad_t rom_dio_d;  // Next memory data pad drive
   glp_pkg::glp_pad_t rom_clk_d;  // Next memory clock pad drive

   ////////////////////////////////////////////////////////////////////////////
   // Address decode, shared by the read and write paths
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      addr_is = (a == ADDR_W'(ofs));
   endfunction

   wire logic hit_cfg = addr_is(paddr, glp_pkg::CFG_OFS);
   wire logic hit_sts = addr_is(paddr, glp_pkg::IRQ_STS_OFS);
   wire logic hit_clr = addr_is(paddr, glp_pkg::IRQ_CLR_OFS);
   wire logic hit_en = addr_is(paddr, glp_pkg::IRQ_EN_OFS);
   wire logic hit_any = hit_cfg | hit_sts | hit_clr | hit_en;
   wire logic setup = psel & ~penable;           // First cycle of a transfer
   wire logic access = psel & penable;           // Completing cycle, no wait states
   wire logic wr = access & pwrite & hit_any;    // Unmapped writes change nothing

   // Zero wait states: the read word was already captured in the setup cycle
   assign pready = access;
   assign pslverr = access & ~hit_any;
   assign prdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Field views of the configuration word
   wire logic [NPIN-1:0] led_sel = cfg_q[glp_pkg::LED_LSB +: NPIN];
   wire logic [NPIN-1:0] pol_sel = cfg_q[glp_pkg::POL_LSB +: NPIN];
   wire logic [2:0] rom_sel = cfg_q[glp_pkg::ROM_LSB +: 3];
   wire logic [NPIN-1:0] drv_pp = cfg_q[glp_pkg::DRV_LSB +: NPIN];
   wire logic [NPIN-1:0] dir_out = cfg_q[glp_pkg::DIR_LSB +: NPIN];
   wire logic [1:0] gpo_val = cfg_q[glp_pkg::GPO_LSB +: 2];
   wire logic [NPIN-1:0] dat_val = cfg_q[glp_pkg::DAT_LSB +: NPIN];
   wire logic [NPIN-1:0] led_src = NPIN'({indicator_3, indicator_2, indicator_1});

   ////////////////////////////////////////////////////////////////////////////
   // Configuration write; reserved bits are masked off and never stored
   assign cfg_d = (wr & hit_cfg) ? (pwdata & glp_pkg::CFG_WMASK) : cfg_q;

   // Configuration register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_q <= glp_pkg::CFG_RST;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path: data bits show the live pins, not the stored data
   wire logic [31:0] cfg_rd = {cfg_q[31:NPIN], pin_in};
   assign rdata_d = !setup ? rdata_q :
                    hit_cfg ? cfg_rd :
                    hit_sts ? 32'(sts_q) :
                    hit_en ? 32'(en_q) : 32'h0000_0000;

   // Read data register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared pins: one drive cell and one level qualifier per pin
   logic [NPIN-1:0] lvl_hit; // Pin held at its active level long enough
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         // Drive selection for this pin
         glp_pin_cell u_cell (
            .led_sel(led_sel[gi]),
            .led_src(led_src[gi]),
            .push_pull(drv_pp[gi]),
            .dir_out(dir_out[gi]),
            .data(dat_val[gi]),
            .pad(pad_d[gi])
         );
         // Level must hold before it counts as an interrupt
         glp_irq_qual #(.HOLD_CYC(HOLD_CYC)) u_qual (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .pin_level(pin_in[gi]),
            .active_high(pol_sel[gi]),
            .hit(lvl_hit[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and output
   wire logic [NPIN-1:0] clr_mask = (wr & hit_clr) ? pwdata[NPIN-1:0] : '0;
   // A level still present in the clear cycle sets the bit again
   assign sts_d = (sts_q & ~clr_mask) | lvl_hit;
   assign en_d = (wr & hit_en) ? pwdata[NPIN-1:0] : en_q;

   // Status and enable registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sts_q <= glp_pkg::IRQ_RST;
         en_q <= glp_pkg::IRQ_RST;
      end else begin
         sts_q <= sts_d;
         en_q <= en_d;
      end
   end

   // Only enabled status bits reach the host
   assign irq = |(sts_q & en_q);

   ////////////////////////////////////////////////////////////////////////////
   // Serial memory pin function; reserved codes float both pins.
   // Changing the code mid memory cycle corrupts that cycle; software must avoid it.
   always_comb begin
      rom_dio_d = '{out: 1'b0, oe_n: 1'b1};
      rom_clk_d = '{out: 1'b0, oe_n: 1'b1};
      unique case (glp_pkg::glp_rom_sel_t'(rom_sel))
         glp_pkg::ROM_EEPROM: begin
            rom_dio_d = '{out: rom_ctl.dio_out, oe_n: rom_ctl.dio_oe_n};
            rom_clk_d = '{out: rom_ctl.clk, oe_n: 1'b0};
         end
         glp_pkg::ROM_GPO_BOTH: begin
            rom_dio_d = '{out: gpo_val[0], oe_n: 1'b0};
            rom_clk_d = '{out: gpo_val[1], oe_n: 1'b0};
         end
         glp_pkg::ROM_GPO_RXDV: begin
            rom_dio_d = '{out: gpo_val[0], oe_n: 1'b0};
            rom_clk_d = '{out: mii.rx_dv, oe_n: 1'b0};
         end
         glp_pkg::ROM_TXEN_GPO: begin
            rom_dio_d = '{out: mii.tx_en, oe_n: 1'b0};
            rom_clk_d = '{out: gpo_val[1], oe_n: 1'b0};
         end
         glp_pkg::ROM_TXEN_RXDV: begin
            rom_dio_d = '{out: mii.tx_en, oe_n: 1'b0};
            rom_clk_d = '{out: mii.rx_dv, oe_n: 1'b0};
         end
         glp_pkg::ROM_MII_CLKS: begin
            rom_dio_d = '{out: mii.tx_clk, oe_n: 1'b0};
            rom_clk_d = '{out: mii.rx_clk, oe_n: 1'b0};
         end
         glp_pkg::ROM_RSV_2, glp_pkg::ROM_RSV_4: begin
            // Reserved, both pins released
            rom_dio_d = '{out: 1'b0, oe_n: 1'b1};
            rom_clk_d = '{out: 1'b0, oe_n: 1'b1};
         end
      endcase
   end

   // The memory controller always sees the data pin
   assign rom_dio_in = rom_data_pin_in;

   ////////////////////////////////////////////////////////////////////////////
   // Pad registers: one cycle after the configuration, glitch free at the pins.
   // The monitored link clocks therefore appear sampled at 250 MHz.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_pad <= {NPIN{2'b01}};
         rom_data_pin <= 2'b01;
         rom_clock_pin <= 2'b01;
      end else begin
         pin_pad <= pad_d;
         rom_data_pin <= rom_dio_d;
         rom_clock_pin <= rom_clk_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Pads are registered, so pad checks compare against their cause one cycle back.
   // The bench may shorten the qualifier; a_short_pulse depth follows HOLD_CYC, a_irq_status_set uses a fixed 11-cycle hold.
   localparam int HOLD_PAST = HOLD_CYC + 1; // Depth back to the first qualifying sample

   a_led_drive: assert property (
      $past(led_sel[0]) |-> (pin_pad[0].oe_n == 1'b0 && pin_pad[0].out == $past(led_src[0])))
      else $error("indicator pin not driven from its source");

   a_irq_status_set: assert property (
      (pin_in[1] == pol_sel[1]) [*8] ##1
      (pin_in[1] == pol_sel[1]) [*3] |=> sts_q[1])
      else $error("held active level did not set status");

   a_irq_gate: assert property (
      !(|en_q) |-> !irq)
      else $error("interrupt output not gated by enable");

   a_irq_raise: assert property (
      $past(lvl_hit[0] && en_q[0] && !(wr && hit_en)) |-> irq)
      else $error("enabled pin event did not raise interrupt");

   a_short_pulse: assert property (
      $rose(sts_q[0]) |-> $past(pin_in[0] == pol_sel[0], 2) && $past(pin_in[0] == pol_sel[0], HOLD_PAST))
      else $error("status set without the level held");

   a_rom_default: assert property (
      $past(rst_n && rom_sel == 3'h0) |-> rom_clock_pin.out == $past(rom_ctl.clk))
      else $error("memory clock pin not driven by controller");

   a_rom_clks: assert property (
      $past(rom_sel == 3'h7) |->
      (rom_data_pin.out == $past(mii.tx_clk) && rom_clock_pin.out == $past(mii.rx_clk)))
      else $error("link clocks not steered to memory pins");

   a_gpo_drive: assert property (
      $past(rom_sel == 3'h1) |->
      (rom_data_pin.out == $past(gpo_val[0]) && rom_clock_pin.out == $past(gpo_val[1])))
      else $error("output-only values not on memory pins");

   a_push_pull: assert property (
      $past(!led_sel[2] && dir_out[2] && drv_pp[2]) |->
      (!pin_pad[2].oe_n && pin_pad[2].out == $past(dat_val[2])))
      else $error("push-pull pin not driving its data");

   a_input_float: assert property (
      $past(!led_sel[1] && !dir_out[1]) |-> pin_pad[1].oe_n)
      else $error("input pin is being driven");

   a_open_drain: assert property (
      $past(!led_sel[0] && dir_out[0] && !drv_pp[0]) |->
      (pin_pad[0].out == 1'b0 && pin_pad[0].oe_n == $past(dat_val[0])))
      else $error("open-drain pin drive wrong");

   a_readback: assert property (
      (setup && hit_cfg) |=> prdata[NPIN-1:0] == $past(pin_in))
      else $error("data bits do not show the pins");

   a_reserved_zero: assert property (
      (cfg_q & ~glp_pkg::CFG_WMASK) == 32'h0000_0000)
      else $error("reserved configuration bit set");

   a_reset_zero: assert property (
      @(posedge clk_sys) disable iff (1'b0) !rst_n |=> (cfg_q == 32'h0 && sts_q == '0 && en_q == '0))
      else $error("state not cleared by reset");

   a_output_drive: assert property (
      $past(!led_sel[1] && dir_out[1] && drv_pp[1]) |-> pin_pad[1].out == $past(dat_val[1]))
      else $error("output pin not showing its data bit");

   a_cfg_write: assert property (
      (wr && hit_cfg) |=> cfg_q == ($past(pwdata) & glp_pkg::CFG_WMASK))
      else $error("configuration write not stored as masked");

   a_unmapped_write: assert property (
      (access && pwrite && !hit_any) |=> ($stable(cfg_q) && $stable(en_q)))
      else $error("unmapped write changed a register");

   a_status_sticky: assert property (
      (sts_q[2] && !(wr && hit_clr && pwdata[2])) |=> sts_q[2])
      else $error("status bit dropped without a clear");

   a_set_wins: assert property (
      lvl_hit[0] |=> sts_q[0])
      else $error("qualified level did not set status");

   a_clear_works: assert property (
      (wr && hit_clr && pwdata[1] && !lvl_hit[1]) |=> !sts_q[1])
      else $error("status bit not cleared");

   a_rom_txen: assert property (
      $past(rom_sel == 3'h6) |->
      (rom_data_pin.out == $past(mii.tx_en) && rom_clock_pin.out == $past(mii.rx_dv)))
      else $error("link strobes not steered to memory pins");

   a_rom_drive_oe: assert property (
      $past(rst_n && rom_sel != 3'h0 && rom_sel != 3'h2 && rom_sel != 3'h4) |->
      (!rom_data_pin.oe_n && !rom_clock_pin.oe_n))
      else $error("output function not driving memory pins");

   a_rom_eeprom_oe: assert property (
      $past(rst_n && rom_sel == 3'h0) |->
      (!rom_clock_pin.oe_n && rom_data_pin.oe_n == $past(rom_ctl.dio_oe_n)))
      else $error("memory controller enables not on pins");

   c_irq_raise: cover property ($rose(irq));
   c_clear: cover property (wr && hit_clr && |sts_q);
   c_led_mode: cover property (led_sel == 3'h7);
   c_rom_txen: cover property (rom_sel == 3'h6 && mii.tx_en);

endmodule // glp_gpio_cfg
`default_nettype wire

// ===== glp_pin_model.sv
// Board around the shared pins: pull-ups plus bench-controlled external drivers.
// Assumes the block registers its pads and the bench never fights a driving pad.
`timescale 1ns/1ns
`default_nettype none
module glp_pin_model (
   input wire glp_pkg::glp_pad_t [2:0] pin_pad,
   input wire glp_pkg::glp_pad_t rom_data_pin,
   input wire logic [2:0] ext_en,
   input wire logic [2:0] ext_val,
   output logic [2:0] pin_in,
   output logic rom_data_pin_in
);
   ////////////////////////////////////////////////////////////////////////////
   // Wire levels: the pad wins, then an outside driver, else the pull-up
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // Open drain releasing a one reads high through the pull-up
         pin_in[i] = !pin_pad[i].oe_n ? pin_pad[i].out : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
   // Memory part idles its data line released, so the pull-up holds it
   assign rom_data_pin_in = rom_data_pin.oe_n ? 1'b1 : rom_data_pin.out;
endmodule // glp_pin_model
`default_nettype wire

// ===== test_glp_gpio_cfg.sv
// Self-checking bench for the pin and indicator configuration block.
// Assumes glp_pkg, the design files and glp_pin_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_glp_gpio_cfg;
   localparam int HOLD = 2; // Short qualifier keeps the run brief
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, w;
   logic pready, pslverr, irq, rom_dio_in, rom_data_pin_in, pol;
   logic [2:0] pin_in, ind = 3'h0, ext_en = 3'h0, ext_val = 3'h0, ev, id, rc, code, pv, dsrc;
   logic [3:0] m, er;
   logic [5:0] ep;
   logic [32:0] exp_head;
   logic [32:0] exp_q[$]; // Expected {pslverr, prdata} per read
   logic [2:0] code_tab[6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
   glp_pkg::glp_pad_t [2:0] pin_pad;
   glp_pkg::glp_pad_t rom_data_pin, rom_clock_pin;
   glp_pkg::glp_rom_ctl_t rom_ctl = '0;
   glp_pkg::glp_mii_t mii = '0;
   int num_errors = 0, check_count = 0, i, k;

   always #2 clk_sys = ~clk_sys;

   glp_gpio_cfg #(.HOLD_CYC(HOLD)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_pad(pin_pad), .indicator_1(ind[0]), .indicator_2(ind[1]), .indicator_3(ind[2]),
      .rom_ctl(rom_ctl), .rom_dio_in(rom_dio_in), .rom_data_pin_in(rom_data_pin_in),
      .rom_data_pin(rom_data_pin), .rom_clock_pin(rom_clock_pin), .mii(mii), .irq(irq));

   glp_pin_model board (.pin_pad(pin_pad), .rom_data_pin(rom_data_pin), .ext_en(ext_en), .ext_val(ext_val),
      .pin_in(pin_in), .rom_data_pin_in(rom_data_pin_in));

   ////////////////////////////////////////////////////////////////////////////
   // Reporting
   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
         num_errors++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // APB master: request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk(32'h0, 32'h1, "pready timeout");
         wrap_up();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // Let n edges pass, then step off the edge so registered pads have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Read monitor: every completed read takes the oldest expectation
   always @(posedge clk_sys) begin
      if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
         check_count++;
         if (exp_q.size() == 0) begin
            $display("FAIL %0t read without expectation", $time);
            num_errors++;
         end else begin
            exp_head = exp_q.pop_front();
            if ({pslverr, prdata} !== exp_head) begin
               $display("FAIL %0t read got %h exp %h", $time, {pslverr, prdata}, exp_head);
               num_errors++;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      w = $urandom(6150);
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Reset state; released pins read high through the pull-ups
      rd(glp_pkg::CFG_OFS, 33'h7);
      rd(glp_pkg::IRQ_STS_OFS, 33'h0);
      rd(glp_pkg::IRQ_EN_OFS, 33'h0);
      chk(32'(pin_pad), 32'h15, "reset pads");
      rd(8'h10, 33'h1_0000_0000);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      rd(glp_pkg::CFG_OFS, 33'h7);
      rd(glp_pkg::IRQ_CLR_OFS, 33'h0);
      // Random configurations: reserved bits set too, only legal memory codes
      for (k = 0; k < 18; k++) begin
         code = code_tab[k % 6];
         m = 4'($urandom);
         id = 3'($urandom);
         rc = 3'($urandom);
         ev = 3'($urandom);
         w = ($urandom & 32'hff8f_ffff) | ({29'h0, code} << 20);
         @(posedge clk_sys);
         mii <= m;
         ind <= id;
         rom_ctl <= rc;
         ext_val <= ev;
         ext_en <= ~w[10:8] & ~w[30:28];
         apb(1'b1, glp_pkg::CFG_OFS, w);
         cyc(2);
         for (i = 0; i < 3; i++) begin
            // Indicator, input, push-pull and open-drain cases in priority order
            if (w[28+i]) {ep[2*i+:2], pv[i]} = {id[i], 1'b0, id[i]};
            else if (!w[8+i]) {ep[2*i+:2], pv[i]} = {w[16+i] & w[i], 1'b1, ev[i]};
            else if (w[16+i]) {ep[2*i+:2], pv[i]} = {w[i], 1'b0, w[i]};
            else {ep[2*i+:2], pv[i]} = {1'b0, w[i], w[i]};
         end
         chk(32'(pin_pad), 32'(ep), "shared pads");
         rd(glp_pkg::CFG_OFS, {1'b0, (w & glp_pkg::CFG_WMASK & 32'hffff_fff8) | {29'h0, pv}});
         dsrc = (code == 3'h7) ? m[1] : (code > 3'h4) ? m[3] : w[3];
         er = {dsrc, 1'b0, (code == 3'h7) ? m[0] : code[1] ? m[2] : w[4], 1'b0};
         if (code == 3'h0) er = {rc[2], rc[1], rc[0], 1'b0};
         chk(32'({rom_data_pin, rom_clock_pin}), 32'(er), "memory pads");
         chk(32'(rom_dio_in), 32'(er[2] | er[3]), "memory data in");
      end
      // Interrupts per pin; pin 1 active high, the others active low
      for (i = 0; i < 3; i++) begin
         pol = i[0];
         ev = 3'h7;
         ev[i] = ~pol;
         @(posedge clk_sys);
         ext_en <= 3'h7;
         ext_val <= ev;
         apb(1'b1, glp_pkg::CFG_OFS, 32'(pol) << (24 + i));
         apb(1'b1, glp_pkg::IRQ_EN_OFS, 32'h1 << i);
         apb(1'b1, glp_pkg::IRQ_CLR_OFS, 32'h7);
         cyc(HOLD + 4);
         rd(glp_pkg::IRQ_STS_OFS, 33'h0);
         @(posedge clk_sys);
         ext_val[i] <= pol;
         @(posedge clk_sys);
         ext_val[i] <= ~pol;
         cyc(HOLD + 4);
         rd(glp_pkg::IRQ_STS_OFS, 33'h0);
         @(posedge clk_sys);
         ext_val[i] <= pol;
         cyc(HOLD + 4);
         chk(32'(irq), 32'h1, "irq raised");
         rd(glp_pkg::IRQ_STS_OFS, 33'h1 << i);
         // Level still held: the set must win over the clear
         apb(1'b1, glp_pkg::IRQ_CLR_OFS, 32'h1 << i);
         rd(glp_pkg::IRQ_STS_OFS, 33'h1 << i);
         @(posedge clk_sys);
         ext_val[i] <= ~pol;
         apb(1'b1, glp_pkg::IRQ_EN_OFS, 32'h0);
         cyc(1);
         chk(32'(irq), 32'h0, "irq masked");
         rd(glp_pkg::IRQ_STS_OFS, 33'h1 << i);
         apb(1'b1, glp_pkg::IRQ_CLR_OFS, 32'h1 << i);
         rd(glp_pkg::IRQ_STS_OFS, 33'h0);
      end
      // Second reset in mid run: everything back to zero, pads released
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(glp_pkg::CFG_OFS, 33'h7);
      rd(glp_pkg::IRQ_EN_OFS, 33'h0);
      chk(32'(pin_pad), 32'h15, "pads after reset");
      cyc(4);
      chk(32'(exp_q.size()), 32'h0, "reads left over");
      wrap_up();
   end
endmodule // test_glp_gpio_cfg
`default_nettype wire
